// *** sim/valley_switching_pwm_control_tb.sv ***
// bench for the pwm control
`timescale 1ns/100ps
`default_nettype none
module valley_switching_pwm_control_tb;
    localparam int EVAL = 200;
    localparam int LONG_RING = 20;
    localparam int OFF_LIM = 60;
    localparam int ON_LIM = 40;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic fb_above_low_hl = 1'b0, fb_above_low_ll = 1'b0, fb_above_reset = 1'b0;
    logic fb_above_high_hl = 1'b0, fb_above_high_ll = 1'b0, line_high = 1'b0;
    logic valley_sense_above_ovp = 1'b0, cs_above_short_winding = 1'b0, ring_hi = 1'b0;
    logic cs_above_fb, cs_above_limit, valley_sense_above_detect, valley_sense_above_ring_sel;
    logic gate_drive, latched_off;
    logic [2:0] valley_select, valley_count, sel_exp, sel_lo;
    logic [7:0] ramp_cyc = 8'h20, lim_cyc = 8'h30, valley_gap = 8'h04, valley_num = 8'h03;
    logic [31:0] rnd_q = 32'hD112232F;
    int error_cnt = 0, total_checks = 0, cyc = 0, on_n = 0, off_n = 0, vl_n = 0, m;
    logic gp = 1'b0, dp = 1'b0, ring_c = 1'b0;
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    valley_switching_pwm_control #(.EVAL_CYCLES(EVAL), .SHORT_RING_CYC(5),
        .LONG_RING_CYC(LONG_RING), .OFF_LIMIT_CYC(OFF_LIM), .ON_LIMIT_CYC(ON_LIM),
        .LEB_CYC(6), .SW_BLANK_CYC(5), .OVP_BLANK_CYC(25)) DUT (.core_clk(core_clk),
        .rst(rst), .fb_above_low_hl(fb_above_low_hl), .fb_above_low_ll(fb_above_low_ll),
        .fb_above_high_hl(fb_above_high_hl), .fb_above_high_ll(fb_above_high_ll),
        .fb_above_reset(fb_above_reset), .line_high(line_high),
        .valley_sense_above_detect(valley_sense_above_detect),
        .valley_sense_above_ring_sel(valley_sense_above_ring_sel),
        .valley_sense_above_ovp(valley_sense_above_ovp), .cs_above_fb(cs_above_fb),
        .cs_above_limit(cs_above_limit), .cs_above_short_winding(cs_above_short_winding),
        .gate_drive(gate_drive), .latched_off(latched_off), .valley_select(valley_select),
        .valley_count(valley_count));
    vsw_stage_model u_stage (.core_clk(core_clk), .gate_drive(gate_drive),
        .ramp_cyc(ramp_cyc), .lim_cyc(lim_cyc), .valley_gap(valley_gap),
        .valley_num(valley_num), .ring_hi(ring_hi), .cs_above_fb(cs_above_fb),
        .cs_above_limit(cs_above_limit), .valley_sense_above_detect(valley_sense_above_detect),
        .valley_sense_above_ring_sel(valley_sense_above_ring_sel));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] nxt();
        rnd_q = rnd_q ^ (rnd_q << 13);
        rnd_q = rnd_q ^ (rnd_q >> 17);
        rnd_q = rnd_q ^ (rnd_q << 5);
        return rnd_q;
    endfunction
    // next select: 0 up 1 hold 2 down 3 one
    function automatic logic [2:0] nsel(input logic [2:0] s, input int a);
        if (a == 0) return (s < 3'h7) ? s + 3'h1 : s;
        if (a == 2) return (s > 3'h1) ? s - 3'h1 : s;
        return (a == 3) ? 3'h1 : s;
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_val3(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded wait for gate or latch
    task automatic wait_sig(input logic v, input logic use_latch);
        for (int i = 0; i < 200 && (use_latch ? latched_off : gate_drive) !== v; i++)
            @(posedge core_clk);
        if ((use_latch ? latched_off : gate_drive) !== v) begin
            error_cnt++;
            end_sim();
        end
    endtask
    task automatic wait_to(input int t);
        while (cyc < t) @(posedge core_clk);
    endtask
    // cycles since reset
    always @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;
    // ****************************************
    // switching monitor
    // ****************************************
    always @(posedge core_clk) begin
        if (rst || latched_off) begin
            {on_n, off_n, vl_n, gp, ring_c, sel_lo} = {96'h0, 1'b0, 1'b0, 3'h7};
        end else if (gate_drive && !gp) begin
            chk_bit(vl_n >= sel_lo || off_n >= OFF_LIM - 2, 1'b1);
            if (!ring_c) chk_bit(off_n >= LONG_RING, 1'b1);
            {on_n, gp} = {32'd1, 1'b1};
        end else if (gate_drive) begin
            on_n++;
        end else begin
            m = ((ramp_cyc < lim_cyc) ? ramp_cyc : lim_cyc) + 6;
            m = (m < ON_LIM) ? m : ON_LIM;
            if (gp && !cs_above_short_winding) chk_bit(on_n >= m - 3 && on_n <= m + 3, 1'b1);
            if (gp) {off_n, vl_n, ring_c, sel_lo} = {64'h0, ring_hi, 3'h7};
            gp = 1'b0;
            off_n++;
            if (dp && !valley_sense_above_detect) vl_n++;
            if (valley_select < sel_lo) sel_lo = valley_select;
        end
        dp = valley_sense_above_detect;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int a;
        logic ln;
        logic [31:0] nz;
        sel_exp = 3'h1;
        repeat (6) @(posedge core_clk);
        chk_val3(valley_select, 3'h1);
        chk_val3(valley_count, 3'h0);
        rst <= 1'b0;
        // 8 up, 7 down, then random
        for (int p = 0; p <= 40; p++) begin
            wait_to(p * EVAL + 20);
            if (p > 0) chk_val3(valley_select, sel_exp);
            if (p == 40) break;
            a = (p < 8) ? 0 : ((p < 15) ? 2 : int'(nxt() % 4));
            sel_exp = nsel(sel_exp, a);
            wait_sig(1'b0, 1'b0);
            nz = nxt();
            {ramp_cyc, lim_cyc} <= {8'(nz[7:0] % 53 + 8), 8'(nz[15:8] % 73 + 8)};
            {valley_gap, valley_num, ring_hi} <= {8'(nz[17:16] + 2), 8'(nz[23:20] % 10), nz[24]};
            wait_to(p * EVAL + 70);
            ln = nz[25];
            line_high <= ln;
            {fb_above_low_ll, fb_above_high_ll} <= ln ? nz[27:26] : 2'b00;
            {fb_above_low_hl, fb_above_high_hl} <= ln ? 2'b00 : nz[27:26];
            wait_to(p * EVAL + 90);
            if (ln) {fb_above_low_hl, fb_above_high_hl} <= {a >= 1, a >= 2};
            else {fb_above_low_ll, fb_above_high_ll} <= {a >= 1, a >= 2};
            fb_above_reset <= (a == 3);
            wait_to(p * EVAL + 96);
            {fb_above_low_hl, fb_above_high_hl, fb_above_low_ll, fb_above_high_ll} <= 4'h0;
            fb_above_reset <= 1'b0;
        end
        $display("test selection done");
        {ramp_cyc, lim_cyc, valley_num} <= {8'd200, 8'd200, 8'd0};
        wait_sig(1'b1, 1'b0);
        wait_sig(1'b0, 1'b0);
        valley_sense_above_ovp <= 1'b1;
        repeat (10) @(posedge core_clk);
        valley_sense_above_ovp <= 1'b0;
        repeat (30) @(posedge core_clk);
        chk_bit(latched_off, 1'b0);
        wait_sig(1'b1, 1'b0);
        cs_above_short_winding <= 1'b1;
        repeat (3) @(posedge core_clk);
        cs_above_short_winding <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk_bit(latched_off, 1'b0);
        wait_sig(1'b0, 1'b0);
        wait_sig(1'b1, 1'b0);
        cs_above_short_winding <= 1'b1;
        for (int i = 0; i < 20 && latched_off !== 1'b1; i++) @(posedge core_clk);
        chk_bit(latched_off, 1'b1);
        {cs_above_short_winding, valley_sense_above_ovp, fb_above_reset} <= 3'b011;
        repeat (300) @(posedge core_clk) chk_bit(latched_off && !gate_drive, 1'b1);
        {rst, valley_sense_above_ovp, fb_above_reset} <= 3'b100;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk_bit(latched_off, 1'b0);
        $display("test winding done");
        wait_sig(1'b1, 1'b0);
        wait_sig(1'b0, 1'b0);
        valley_sense_above_ovp <= 1'b1;
        for (int i = 0; i < 40 && latched_off !== 1'b1; i++) @(posedge core_clk);
        chk_bit(latched_off, 1'b1);
        $display("test ovp done");
        end_sim();
    end
endmodule // valley_switching_pwm_control_tb
`default_nettype wire

// *** sim/vsw_properties.sv ***
// port assertions, pwm control
`timescale 1ns/100ps
`default_nettype none
module vsw_properties #(
    parameter int ON_LIMIT_CYC = 40,
    parameter int OFF_LIMIT_CYC = 60,
    parameter int SHORT_RING_CYC = 5,
    parameter int LEB_CYC = 6
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_above_fb,
    input wire logic cs_above_limit,
    input wire logic gate_drive,
    input wire logic latched_off,
    input wire logic [2:0] valley_select,
    input wire logic [2:0] valley_count
);
    // ****************************************
    // gate run lengths
    // ****************************************
    logic [15:0] on_len_q; // gate high run
    logic [15:0] off_len_q; // gate low run
    // on run
    always_ff @(posedge core_clk) begin
        on_len_q <= (rst || !gate_drive) ? 16'h0000 : on_len_q + 16'h0001;
    end
    // off run
    always_ff @(posedge core_clk) begin
        off_len_q <= (rst || gate_drive || latched_off) ? 16'h0000 : off_len_q + 16'h0001;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_state: assert property (disable iff (1'b0) rst |=> !gate_drive && !latched_off
        && valley_select == 3'h1 && valley_count == 3'h0) else $error("bad reset");
    a_select_range: assert property (
        valley_select >= 3'h1 && valley_select <= 3'h7) else $error("select range");
    a_select_step: assert property ($changed(valley_select) |-> valley_select == 3'h1
        || valley_select == $past(valley_select) + 3'h1
        || valley_select == $past(valley_select) - 3'h1) else $error("select jump");
    a_count_step: assert property ($changed(valley_count) && valley_count != 3'h0
        |-> valley_count == $past(valley_count) + 3'h1) else $error("count jump");
    a_count_clear: assert property ($rose(gate_drive) |-> valley_count == 3'h0)
        else $error("count not clear");
    a_clear_turns_on: assert property (valley_count == 3'h0 && $past(valley_count) != 3'h0
        |=> gate_drive) else $error("clear no turn-on");
    a_min_on_time: assert property (
        $rose(gate_drive) |-> (gate_drive || latched_off)[*7]) else $error("on too short");
    a_max_on_time: assert property (on_len_q <= ON_LIMIT_CYC)
        else $error("on too long");
    a_ring_hold: assert property ($rose(gate_drive) |-> off_len_q >= SHORT_RING_CYC)
        else $error("on in ringing");
    a_max_off_time: assert property (!latched_off |-> off_len_q <= OFF_LIMIT_CYC + 2)
        else $error("off too long");
    a_fb_turn_off: assert property (
        (gate_drive && cs_above_fb && on_len_q >= LEB_CYC + 2)[*4] |=> !gate_drive)
        else $error("fb off late");
    a_limit_turn_off: assert property (
        (gate_drive && cs_above_limit && on_len_q >= LEB_CYC + 2)[*4] |=> !gate_drive)
        else $error("limit off late");
    a_latch_gate: assert property (latched_off |=> !gate_drive)
        else $error("gate in latch");
    a_latch_hold: assert property (latched_off |=> latched_off)
        else $error("latch lost");
    c_turn_on: cover property ($rose(gate_drive));
    c_latched: cover property ($rose(latched_off));
    c_select_top: cover property (valley_select == 3'h7);
endmodule // vsw_properties
bind valley_switching_pwm_control vsw_properties #(.ON_LIMIT_CYC(ON_LIMIT_CYC),
    .OFF_LIMIT_CYC(OFF_LIMIT_CYC), .SHORT_RING_CYC(SHORT_RING_CYC), .LEB_CYC(LEB_CYC))
    u_vsw_properties (.core_clk(core_clk), .rst(rst), .cs_above_fb(cs_above_fb),
    .cs_above_limit(cs_above_limit), .gate_drive(gate_drive), .latched_off(latched_off),
    .valley_select(valley_select), .valley_count(valley_count));
`default_nettype wire

// *** sim/vsw_stage_model.sv ***
// flyback stage model
`timescale 1ns/100ps
`default_nettype none
module vsw_stage_model (
    input wire logic core_clk,
    input wire logic gate_drive,
    input wire logic [7:0] ramp_cyc,
    input wire logic [7:0] lim_cyc,
    input wire logic [7:0] valley_gap,
    input wire logic [7:0] valley_num,
    input wire logic ring_hi,
    output logic cs_above_fb,
    output logic cs_above_limit,
    output logic valley_sense_above_detect,
    output logic valley_sense_above_ring_sel
);
    logic gate_q = 1'b0; // last gate
    logic [7:0] cnt_q = 8'h00; // run
    logic [7:0] ph; // ring phase
    assign ph = cnt_q - 8'h03;
    // cycles since gate change
    always @(posedge core_clk) begin
        gate_q <= gate_drive;
        cnt_q <= (gate_drive != gate_q) ? 8'h00 : ((cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01);
    end
    // current ramp comparators
    always @(posedge core_clk) begin
        cs_above_fb <= gate_drive && (cnt_q >= ramp_cyc);
        cs_above_limit <= gate_drive && (cnt_q >= lim_cyc);
    end
    // valley_num valleys, valley_gap apart
    always @(posedge core_clk) begin
        valley_sense_above_detect <= !gate_drive && (cnt_q >= 8'h03)
            && ((ph % valley_gap) < (valley_gap >> 1)) && ((ph / valley_gap) < valley_num);
        valley_sense_above_ring_sel <= gate_drive ? ring_hi : valley_sense_above_detect;
    end
endmodule // vsw_stage_model
`default_nettype wire

// *** verilog/persist_filter.sv ***
// spike filter: high after a held run
`timescale 1ns/100ps
`default_nettype none
module persist_filter #(
    parameter int CYCLES = 5
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic din,
    output logic dout
);
    // run length of the high input
    logic [15:0] run_q;
    always_ff @(posedge core_clk) begin
        if (rst || !enable || !din) begin
            run_q <= 16'h0000;
            dout <= 1'b0;
        end else begin
            if (run_q < 16'(CYCLES)) begin
                run_q <= run_q + 16'h0001;
            end
            dout <= (run_q >= 16'(CYCLES - 1));
        end
    end
endmodule // persist_filter
`default_nettype wire

// *** verilog/sync2.sv ***
// two flop synchroniser
`timescale 1ns/100ps
`default_nettype none
module sync2 (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    // first stage, read only by second stage
    logic meta_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // sync2
`default_nettype wire

// *** verilog/valley_switching_pwm_control.sv ***
// valley-switching on/off control with protection latches
`include "vsw_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module valley_switching_pwm_control
    import vsw_pkg::*;
#(
    parameter int EVAL_CYCLES = `EVAL_CYCLES,
    parameter int SHORT_RING_CYC = `SHORT_RING_CYC,
    parameter int LONG_RING_CYC = `LONG_RING_CYC,
    parameter int OFF_LIMIT_CYC = `OFF_LIMIT_CYC,
    parameter int ON_LIMIT_CYC = `ON_LIMIT_CYC,
    parameter int LEB_CYC = `LEB_CYC,
    parameter int SW_BLANK_CYC = `SW_BLANK_CYC,
    parameter int OVP_BLANK_CYC = `OVP_BLANK_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    // feedback above low count threshold (high-line set)
    input wire logic fb_above_low_hl,
    // feedback above low count threshold (low-line set)
    input wire logic fb_above_low_ll,
    // feedback above high count threshold (high-line set)
    input wire logic fb_above_high_hl,
    // feedback above high count threshold (low-line set)
    input wire logic fb_above_high_ll,
    // feedback above counter reset threshold
    input wire logic fb_above_reset,
    // line voltage detected high
    input wire logic line_high,
    // valley sense above valley detect threshold
    input wire logic valley_sense_above_detect,
    // valley sense above ringing select threshold
    input wire logic valley_sense_above_ring_sel,
    // valley sense above output overvoltage threshold
    input wire logic valley_sense_above_ovp,
    // scaled current sense above regulation input
    input wire logic cs_above_fb,
    // current limit comparator tripped
    input wire logic cs_above_limit,
    // current sense above short winding threshold
    input wire logic cs_above_short_winding,
    output logic gate_drive,
    output logic latched_off,
    output logic [2:0] valley_select,
    output logic [2:0] valley_count
);

    // ************************************************************
    // input synchronisation
    // ************************************************************

    // synchronised comparator levels
    logic [11:0] raw_in;
    logic [11:0] syn;
    assign raw_in = {fb_above_low_hl, fb_above_low_ll, fb_above_high_hl,
                     fb_above_high_ll, fb_above_reset, line_high,
                     valley_sense_above_detect, valley_sense_above_ring_sel,
                     valley_sense_above_ovp, cs_above_fb, cs_above_limit,
                     cs_above_short_winding};

    // (RQ24) synchronise every comparator
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_sync
            sync2 u_sync (
                .core_clk(core_clk),
                .rst(rst),
                .din(raw_in[gi]),
                .dout(syn[gi])
            );
        end
    endgenerate

    // named inputs
    logic s_low_hl, s_low_ll, s_high_hl, s_high_ll, s_reset, s_line;
    logic s_detect, s_ring_sel, s_ovp, s_pwm, s_limit, s_sw;
    assign {s_low_hl, s_low_ll, s_high_hl, s_high_ll, s_reset, s_line,
            s_detect, s_ring_sel, s_ovp, s_pwm, s_limit, s_sw} = syn;

    // (RQ8) thresholds picked by line level
    logic s_low, s_high;
    assign s_low = s_line ? s_low_hl : s_low_ll;
    assign s_high = s_line ? s_high_hl : s_high_ll;

    // ************************************************************
    // valley selection up/down counter
    // ************************************************************

    // evaluation period timer
    logic [31:0] eval_cnt_q;
    // feedback went above low / high during the period
    logic seen_low_q, seen_high_q;
    // end of period strobe
    logic eval_end;
    assign eval_end = (eval_cnt_q == 32'(EVAL_CYCLES - 1));

    // (RQ1) period timer
    always_ff @(posedge core_clk) begin
        if (rst || eval_end) begin
            eval_cnt_q <= 32'h00000000;
        end else begin
            eval_cnt_q <= eval_cnt_q + 32'h00000001;
        end
    end

    // sticky flags per period
    always_ff @(posedge core_clk) begin
        if (rst || eval_end) begin
            seen_low_q <= 1'b0;
            seen_high_q <= 1'b0;
        end else begin
            seen_low_q <= seen_low_q | s_low;
            seen_high_q <= seen_high_q | s_high;
        end
    end

    // counter register, starts at one
    logic [2:0] sel_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // (RQ7) start at one
            sel_q <= `SEL_MIN;
        end else if (s_reset) begin
            // (RQ5) reset threshold loads one
            sel_q <= `SEL_MIN;
        end else if (eval_end) begin
            if (!(seen_low_q | s_low)) begin
                // (RQ2) (RQ6) count up saturating
                if (sel_q != `SEL_MAX) begin
                    sel_q <= sel_q + 3'h1;
                end
            end else if (seen_high_q | s_high) begin
                // (RQ4) (RQ6) count down saturating
                if (sel_q != `SEL_MIN) begin
                    sel_q <= sel_q - 3'h1;
                end
            end
            // (RQ3) otherwise hold
        end
    end

    // ************************************************************
    // gate phase control
    // ************************************************************

    // current phase and timers
    phase_t phase_q;
    logic [15:0] ring_cnt_q;
    logic [15:0] off_cnt_q;
    logic [15:0] on_cnt_q;
    logic [2:0] vcnt_q;
    logic detect_prev_q;
    logic ring_long_q;
    logic sw_filt;
    logic ovp_trip;

    // falling crossing of the valley detect threshold
    logic valley_edge;
    assign valley_edge = detect_prev_q & ~s_detect;

    // leading edge blanking over
    logic leb_done;
    assign leb_done = (on_cnt_q >= 16'(LEB_CYC));

    // (RQ25) first off request wins
    logic off_req;
    assign off_req = (leb_done & (s_pwm | s_limit)) |
                     (on_cnt_q >= 16'(ON_LIMIT_CYC - 1));

    // turn-on request while off
    logic on_req;
    assign on_req = (off_cnt_q >= 16'(OFF_LIMIT_CYC - 1)) |
                    ((phase_q == PH_OFF_WAIT) & (vcnt_q >= sel_q));

    // ring time in force
    logic [15:0] ring_len;
    assign ring_len = ring_long_q ? 16'(LONG_RING_CYC) : 16'(SHORT_RING_CYC);

    // phase sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q <= PH_OFF_RING;
        end else begin
            case (phase_q)
                PH_OFF_RING: begin
                    if (ovp_trip) begin
                        phase_q <= PH_LATCHED;
                    end else if (off_cnt_q >= 16'(OFF_LIMIT_CYC - 1)) begin
                        // (RQ16) off-time limit overrides
                        phase_q <= PH_ON;
                    end else if (ring_cnt_q >= ring_len - 16'h0001) begin
                        // (RQ14) low until suppression ends
                        phase_q <= PH_OFF_WAIT;
                    end
                end
                PH_OFF_WAIT: begin
                    if (ovp_trip) begin
                        phase_q <= PH_LATCHED;
                    end else if (on_req) begin
                        // (RQ15) (RQ16) valley reached or limit
                        phase_q <= PH_ON;
                    end
                end
                PH_ON: begin
                    if (sw_filt) begin
                        // (RQ22) short winding latches off
                        phase_q <= PH_LATCHED;
                    end else if (off_req) begin
                        // (RQ17) (RQ19) (RQ20) turn off
                        phase_q <= PH_OFF_RING;
                    end
                end
                PH_LATCHED: begin
                    // (RQ23) held until power-down reset
                    phase_q <= PH_LATCHED;
                end
                default: begin
                    phase_q <= PH_OFF_RING;
                end
            endcase
        end
    end

    // (RQ13) ring length picked at turn-off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ring_long_q <= 1'b1;
        end else if (phase_q == PH_ON) begin
            ring_long_q <= ~s_ring_sel;
        end
    end

    // off timers
    always_ff @(posedge core_clk) begin
        if (rst || phase_q == PH_ON || phase_q == PH_LATCHED) begin
            ring_cnt_q <= 16'h0000;
            off_cnt_q <= 16'h0000;
        end else begin
            if (phase_q == PH_OFF_RING && ring_cnt_q != 16'hFFFF) begin
                ring_cnt_q <= ring_cnt_q + 16'h0001;
            end
            if (off_cnt_q != 16'hFFFF) begin
                off_cnt_q <= off_cnt_q + 16'h0001;
            end
        end
    end

    // (RQ18) on-time counter for blanking and limit
    always_ff @(posedge core_clk) begin
        if (rst || phase_q != PH_ON) begin
            on_cnt_q <= 16'h0000;
        end else if (on_cnt_q != 16'hFFFF) begin
            on_cnt_q <= on_cnt_q + 16'h0001;
        end
    end

    // ************************************************************
    // valley counter
    // ************************************************************

    // previous detect level for edge finding
    always_ff @(posedge core_clk) begin
        if (rst) begin
            detect_prev_q <= 1'b0;
        end else begin
            detect_prev_q <= s_detect;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || phase_q == PH_ON) begin
            // (RQ11) cleared from gate rise
            vcnt_q <= 3'h0;
        end else if (valley_edge && vcnt_q != `VALLEY_MAX) begin
            // (RQ10) (RQ9) count valleys up to 7
            vcnt_q <= vcnt_q + 3'h1;
        end
    end

    // ************************************************************
    // protection filters
    // ************************************************************

    // (RQ12) overvoltage blanking while off
    logic off_phase;
    assign off_phase = (phase_q == PH_OFF_RING) || (phase_q == PH_OFF_WAIT);
    persist_filter #(.CYCLES(OVP_BLANK_CYC)) u_ovp (
        .core_clk(core_clk),
        .rst(rst),
        .enable(off_phase),
        .din(s_ovp),
        .dout(ovp_trip)
    );

    // (RQ21) short winding spike blanking
    persist_filter #(.CYCLES(SW_BLANK_CYC)) u_sw (
        .core_clk(core_clk),
        .rst(rst),
        .enable(phase_q == PH_ON),
        .din(s_sw),
        .dout(sw_filt)
    );

    // ************************************************************
    // registered outputs
    // ************************************************************

    // gate and status outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gate_drive <= 1'b0;
            latched_off <= 1'b0;
            valley_select <= `SEL_MIN;
            valley_count <= 3'h0;
        end else begin
            gate_drive <= (phase_q == PH_ON);
            latched_off <= (phase_q == PH_LATCHED);
            valley_select <= sel_q;
            valley_count <= (phase_q == PH_ON) ? 3'h0 : vcnt_q;
        end
    end

endmodule // valley_switching_pwm_control
`default_nettype wire

// *** verilog/vsw_consts.svh ***
// timing counts and limits
// How it works
// (RQ1) judge feedback every 48 ms period, update once
// (RQ2) feedback always below low: count up, max 7
// (RQ3) above low never above high: hold value
// (RQ4) above high never above reset: count down, min 1
// (RQ5) above reset threshold: load counter with 1
// (RQ6) valley selection always within 1 to 7
// (RQ7) valley selection starts at 1 after reset
// (RQ8) count thresholds chosen by line voltage level
// (RQ9) valley counter stays within 0 to 7
// (RQ10) each valley detected while off adds one
// (RQ11) valley counter cleared on gate rising edge
// (RQ12) overvoltage while off latches off after blanking
// (RQ13) low sense voltage selects long ringing time
// (RQ14) gate held low during ringing suppression
// (RQ15) turn on when valleys reach selection value
// (RQ16) turn on anyway after off-time limit
// (RQ17) current sense above feedback turns gate off
// (RQ18) blank off comparator for leading blank time
// (RQ19) turn off after on-time limit
// (RQ20) current limit turns off, also blanked
// (RQ21) short winding needs persistence for blank time
// (RQ22) filtered short winding during on-time latches off
// (RQ23) latch cleared only by power-down reset
// (RQ24) inputs synchronised, all times clocked counters
// (RQ25) first off request ends the on period
`ifndef VSW_CONSTS_SVH
`define VSW_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define EVAL_PERIOD_MS 48
`define EVAL_CYCLES ((`EVAL_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define SEL_MIN 3'h1
`define SEL_MAX 3'h7
`define VALLEY_MAX 3'h7
`define SHORT_RING_NS 2500
`define LONG_RING_NS 25000
`define OFF_LIMIT_NS 42800
`define ON_LIMIT_NS 30000
`define LEB_NS 220
`define SW_BLANK_NS 190
`define OVP_BLANK_NS 1000
`define SHORT_RING_CYC ((`SHORT_RING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_RING_CYC ((`LONG_RING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_LIMIT_CYC (`OFF_LIMIT_NS / `CLK_PERIOD_NS)
`define ON_LIMIT_CYC (`ON_LIMIT_NS / `CLK_PERIOD_NS)
`define LEB_CYC ((`LEB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SW_BLANK_CYC ((`SW_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVP_BLANK_CYC ((`OVP_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** verilog/vsw_pkg.sv ***
// shared types
package vsw_pkg;
    // gate phase of the switching cycle
    typedef enum logic [1:0] {
        PH_OFF_RING = 2'b00,
        PH_OFF_WAIT = 2'b01,
        PH_ON = 2'b10,
        PH_LATCHED = 2'b11
    } phase_t;
endpackage
